// ### adc_burst_pkg.sv
// Constants, types and helper functions for the burst sequencer.
// Assumes a single 200 MHz reference clock drives every consumer.
`default_nettype none
package adc_burst_pkg;
    // -----------------------------------------------------------
    // Register map
    // -----------------------------------------------------------
    localparam logic [7:0] PAGE_CFG = 8'h0F;
    localparam logic [7:0] PAGE_DATA = 8'h00;
    localparam logic [7:0] PWR_ADDR = 8'hBA;
    localparam logic [7:0] TRK_ADDR = 8'hBD;
    localparam logic [7:0] RES_ADDR = 8'hBE;
    localparam logic [3:0] PWR_RESET = 4'hF;
    localparam logic [5:0] TRK_RESET = 6'h16;
    localparam logic [15:0] ACC_RESET = 16'h0000;
    // -----------------------------------------------------------
    // Timing
    // -----------------------------------------------------------
    localparam int REF_CLK_NS = 5;
    localparam int OSC_PERIOD_NS = 50;
    localparam int OSC_DIV = OSC_PERIOD_NS / REF_CLK_NS;
    localparam logic [3:0] OSC_DIV_LAST = 4'(OSC_DIV - 1);
    localparam int PWR_UNIT_NS = 400;
    localparam int PWR_UNIT_TICKS = (PWR_UNIT_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
    localparam int TRK_UNIT_NS = 50;
    localparam int TRK_UNIT_TICKS = (TRK_UNIT_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
    localparam logic [7:0] TRK_SPAN = 8'h40;
    localparam logic [7:0] EXTRA_TRACK_TICKS = 8'h03;
    // -----------------------------------------------------------
    // Field codes
    // -----------------------------------------------------------
    localparam logic [2:0] SJ_LEFT = 3'h4;
    localparam int LEFT_SHIFT = 6;
    localparam logic [2:0] RPT_MAX_CODE = 3'h5;
    // -----------------------------------------------------------
    // Types
    // -----------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
    typedef struct packed {
        logic converterEnable;
        logic burstModeEnable;
        logic delayedTrackSelect;
        logic [2:0] shiftJustifySelect;
        logic [2:0] repeatCount;
    } ctl_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_POWERUP = 6'h02,
        ST_TRACK = 6'h04,
        ST_EXTRA = 6'h08,
        ST_START = 6'h10,
        ST_CONVERT = 6'h20
    } state_t;
    // -----------------------------------------------------------
    // Functions
    // -----------------------------------------------------------
    function automatic logic [7:0] pwrTicks(input logic [3:0] f);
        return 8'((8'(f) + 8'h01) * PWR_UNIT_TICKS);
    endfunction
    function automatic logic [7:0] trkTicks(input logic [5:0] f);
        return 8'((TRK_SPAN - 8'(f)) * TRK_UNIT_TICKS);
    endfunction
    function automatic logic [6:0] repeatTotal(input logic [2:0] code);
        if (code == 3'h0 || code > RPT_MAX_CODE) begin
            return 7'h01;
        end
        return 7'(7'h01 << (code + 3'h1));
    endfunction
    function automatic logic [15:0] formatAcc(input logic [15:0] a, input logic [2:0] sj);
        if (sj < SJ_LEFT) begin
            return a >> sj;
        end
        if (sj == SJ_LEFT) begin
            return 16'(a << LEFT_SHIFT);
        end
        return a;
    endfunction
endpackage
`default_nettype wire

// ### adc_burst_timing_result.sv
// Burst sequencer, delay timing and result high byte of the converter.
// Assumes the converter core pulses convDone with convResult and that
// startConv and the control bits arrive from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module adc_burst_timing_result (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire adc_burst_pkg::sfr_req_t sfrReq,
    output logic [7:0] sfrRdata,
    // Control bits
    input wire adc_burst_pkg::ctl_t ctl,
    // Converter core
    input wire logic startConv,
    input wire logic convDone,
    input wire logic [9:0] convResult,
    output logic convStart,
    output logic convPowered,
    output logic burstBusy
);
    import adc_burst_pkg::*;

    // -----------------------------------------------------------
    // Storage
    // -----------------------------------------------------------
    logic [3:0] pwrField; // Power-up delay field
    logic [5:0] trkField; // Track delay field
    logic [15:0] acc; // Result accumulator
    state_t state; // Sequencer state
    state_t next_state;
    logic [7:0] dlyCnt; // Oscillator ticks left in a delay
    logic [7:0] elapsed; // Ticks spent in the current state
    logic [6:0] convCount; // Conversions done in this burst
    logic [3:0] divCnt; // Oscillator tick divider
    logic oscTick; // One pulse per 50 ns

    // -----------------------------------------------------------
    // Decoding
    // -----------------------------------------------------------
    // Register selects; the page splits registers sharing an address
    wire logic cfgPage = sfrReq.page == PAGE_CFG;
    wire logic selPwr = cfgPage && sfrReq.addr == PWR_ADDR;
    wire logic selTrk = cfgPage && sfrReq.addr == TRK_ADDR;
    wire logic selRes = sfrReq.page == PAGE_DATA && sfrReq.addr == RES_ADDR;
    // Sequencer helpers
    wire logic [15:0] fmtAcc = formatAcc(acc, ctl.shiftJustifySelect);
    wire logic [6:0] burstTotal = ctl.burstModeEnable ? repeatTotal(ctl.repeatCount) : 7'h01;
    wire logic lastConv = 7'(convCount + 7'h01) >= burstTotal;
    wire logic delayEnd = oscTick && dlyCnt == 8'h01;
    wire logic needPowerup = ctl.burstModeEnable && !ctl.converterEnable;
    wire logic mayStart = startConv && (ctl.burstModeEnable || ctl.converterEnable);
    wire state_t afterDelay = ctl.delayedTrackSelect ? ST_EXTRA : ST_START;
    wire logic entering = next_state != state;
    // Load value for the delay counter on entering a timed state
    wire logic [7:0] loadVal = next_state == ST_POWERUP ? pwrTicks(pwrField) :
        next_state == ST_TRACK ? trkTicks(trkField) : EXTRA_TRACK_TICKS;
    // Burst off: enable alone; burst on: enable, or a burst in flight
    wire logic next_powered = ctl.burstModeEnable ?
        (ctl.converterEnable || state != ST_IDLE) : ctl.converterEnable;
    // Read mux; unused bits come back as zero
    wire logic [7:0] readVal = selPwr ? {4'h0, pwrField} :
        selTrk ? {2'h0, trkField} :
        selRes ? fmtAcc[15:8] : 8'h00;

    // -----------------------------------------------------------
    // Oscillator tick
    // -----------------------------------------------------------
    // Single clock domain, so the 20 MHz timebase is an enable pulse
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            divCnt <= 4'h0;
            oscTick <= 1'b0;
        end else begin
            divCnt <= divCnt == OSC_DIV_LAST ? 4'h0 : 4'(divCnt + 4'h1);
            oscTick <= divCnt == OSC_DIV_LAST;
        end
    end

    // -----------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------
    // Next state; the first conversion never passes through TRACK
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (mayStart) begin
                    next_state = needPowerup ? ST_POWERUP : afterDelay;
                end
            end
            ST_POWERUP: begin
                if (delayEnd) begin
                    next_state = afterDelay;
                end
            end
            ST_TRACK: begin
                if (delayEnd) begin
                    next_state = afterDelay;
                end
            end
            ST_EXTRA: begin
                if (delayEnd) begin
                    next_state = ST_START;
                end
            end
            ST_START: begin
                next_state = ST_CONVERT;
            end
            ST_CONVERT: begin
                if (convDone) begin
                    next_state = lastConv ? ST_IDLE : ST_TRACK;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State and handshake outputs
    // Outputs are registered so the core sees clean pulses
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            convStart <= 1'b0;
            burstBusy <= 1'b0;
            convPowered <= 1'b0;
        end else begin
            state <= next_state;
            convStart <= next_state == ST_START;
            burstBusy <= next_state != ST_IDLE;
            convPowered <= next_powered;
        end
    end

    // Delay counter and tick bookkeeping
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dlyCnt <= 8'h00;
            elapsed <= 8'h00;
        end else begin
            dlyCnt <= entering ? loadVal : (oscTick ? 8'(dlyCnt - 8'h01) : dlyCnt);
            elapsed <= entering ? 8'h00 : 8'(elapsed + {7'h00, oscTick});
        end
    end

    // Conversion count; cleared whenever the sequencer idles
    always_ff @(posedge ref_clk) begin
        if (!rstn || state == ST_IDLE) begin
            convCount <= 7'h00;
        end else if (state == ST_CONVERT && convDone) begin
            convCount <= 7'(convCount + 7'h01);
        end
    end

    // -----------------------------------------------------------
    // Registers and accumulator
    // -----------------------------------------------------------
    // Only the documented field bits are stored
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pwrField <= PWR_RESET;
            trkField <= TRK_RESET;
        end else if (sfrReq.wr) begin
            if (selPwr) begin
                pwrField <= sfrReq.wdata[3:0];
            end
            if (selTrk) begin
                trkField <= sfrReq.wdata[5:0];
            end
        end
    end

    // First result of a burst replaces, later ones add.
    // A software write in the same cycle wins: it is explicit intent.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            acc <= ACC_RESET;
        end else if (sfrReq.wr && selRes) begin
            acc[15:8] <= sfrReq.wdata;
        end else if (state == ST_CONVERT && convDone) begin
            acc <= convCount == 7'h00 ? {6'h00, convResult} : 16'(acc + {6'h00, convResult});
        end
    end

    // Read data register, updated on a read strobe only
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sfrRdata <= 8'h00;
        end else if (sfrReq.rd) begin
            sfrRdata <= readVal;
        end
    end

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    // One clock domain; reset masks every check
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Register access, sequencer and timebase rules

    pwr_bit7_zero_a: assert property (sfrReq.rd && selPwr |=> !sfrRdata[7])
        else $error("Power-up bit 7 read nonzero");
    pwr_unused_zero_a: assert property (sfrReq.rd && selPwr |=> sfrRdata[6:4] == 3'h0)
        else $error("Power-up unused bits nonzero");
    powerup_length_a: assert property (state == ST_POWERUP && delayEnd
        |-> 8'(elapsed + 8'h01) == pwrTicks(pwrField))
        else $error("Power-up wait length wrong");
    nonburst_power_a: assert property (!ctl.burstModeEnable
        |=> convPowered == $past(ctl.converterEnable))
        else $error("Power not following enable");
    burst_on_power_a: assert property (ctl.burstModeEnable && ctl.converterEnable
        |=> convPowered)
        else $error("Powered burst dropped power");
    burst_fast_start_a: assert property (state == ST_IDLE && startConv &&
        ctl.burstModeEnable && ctl.converterEnable && !ctl.delayedTrackSelect |=> convStart)
        else $error("Enabled burst did not start at once");
    burst_off_power_a: assert property (needPowerup && state == ST_IDLE
        |=> !convPowered)
        else $error("Idle burst stayed powered");
    burst_wait_first_a: assert property (state == ST_IDLE && startConv && needPowerup
        |=> state == ST_POWERUP ##1 !convStart)
        else $error("Unpowered burst skipped wait");
    track_length_a: assert property (state == ST_TRACK && delayEnd
        |-> 8'(elapsed + 8'h01) == trkTicks(trkField))
        else $error("Track gap length wrong");
    trk_unused_zero_a: assert property (sfrReq.rd && selTrk |=> sfrRdata[7:6] == 2'h0)
        else $error("Track unused bits nonzero");
    extra_track_a: assert property (state == ST_EXTRA && delayEnd
        |-> 8'(elapsed + 8'h01) == EXTRA_TRACK_TICKS)
        else $error("Delayed tracking length wrong");
    first_no_track_a: assert property (state == ST_TRACK |-> convCount != 7'h00)
        else $error("Track gap before first conversion");
    high_read_a: assert property (sfrReq.rd && selRes |=> sfrRdata == $past(fmtAcc[15:8]))
        else $error("High byte read mismatch");
    high_write_a: assert property (sfrReq.wr && selRes |=> acc[15:8] == $past(sfrReq.wdata))
        else $error("High byte write not loaded");
    shift_zero_fill_a: assert property (sfrReq.rd && selRes &&
        ctl.shiftJustifySelect == 3'h3 |=> sfrRdata[7:5] == 3'h0)
        else $error("Shifted read not zero filled");
    left_justify_a: assert property (sfrReq.rd && selRes && ctl.shiftJustifySelect == SJ_LEFT
        |=> sfrRdata == $past(acc[9:2]))
        else $error("Left justify wrong");
    burst_count_a: assert property (state == ST_CONVERT && convDone &&
        7'(convCount + 7'h01) == burstTotal |=> state == ST_IDLE)
        else $error("Burst did not end at count");
    osc_period_a: assert property (oscTick |-> ##10 oscTick)
        else $error("Oscillator tick period wrong");

    // Timebase, counters, start pulse, burst ends and register checks
    osc_gap_a: assert property (oscTick |=> !oscTick [*8] ##1 !oscTick)
        else $error("Oscillator tick came early");
    dly_no_wrap_a: assert property (state inside {ST_POWERUP, ST_TRACK, ST_EXTRA}
        |-> dlyCnt != 8'h00)
        else $error("Delay counter ran out in a timed state");
    start_pulse_a: assert property (convStart |=> !convStart)
        else $error("Start pulse longer than one cycle");
    single_conv_end_a: assert property (!ctl.burstModeEnable &&
        state == ST_CONVERT && convDone |=> state == ST_IDLE)
        else $error("Single conversion did not end");
    burst_end_power_a: assert property (needPowerup && state == ST_CONVERT &&
        convDone && lastConv |=> ##1 !convPowered)
        else $error("Burst without enable stayed powered");
    pwr_write_a: assert property (sfrReq.wr && selPwr
        |=> pwrField == $past(sfrReq.wdata[3:0]))
        else $error("Power-up field write not stored");
    shift_one_fill_a: assert property (sfrReq.rd && selRes &&
        ctl.shiftJustifySelect == 3'h1 |=> !sfrRdata[7])
        else $error("One-bit shift not zero filled");

    // Covers of the main scenarios
    fast_burst_c: cover property (ctl.burstModeEnable && ctl.converterEnable && convStart);
    powerup_burst_c: cover property (state == ST_POWERUP ##[1:200] convStart);
    track_gap_c: cover property (state == ST_TRACK ##[1:200] state == ST_START);
    high_read_c: cover property (sfrReq.rd && selRes && ctl.shiftJustifySelect != 3'h0);
    single_conv_c: cover property (!ctl.burstModeEnable && convStart);
endmodule
`default_nettype wire

// ### adc_burst_timing_result_tb.sv
// Self-checking bench for the burst sequencer and the result high byte.
// Assumes the package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
// Compare two values, count the comparison and report a mismatch
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin errorCnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module adc_burst_timing_result_tb;
    import adc_burst_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    sfr_req_t sfrReq = '0;
    ctl_t ctl = '0;
    logic startConv = 1'b0;
    logic convDone = 1'b0;
    logic [9:0] convResult = 10'h000;
    logic [7:0] sfrRdata;
    logic convStart;
    logic convPowered;
    logic burstBusy;
    int errorCnt = 0;
    int nCompared = 0;
    int seed = 16;
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;
    // ---------------------------------------------------------------
    // Device under test
    // ---------------------------------------------------------------
    adc_burst_timing_result u_adc_burst_timing_result (
        .ref_clk(ref_clk), .rstn(rstn), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .ctl(ctl),
        .startConv(startConv), .convDone(convDone), .convResult(convResult),
        .convStart(convStart), .convPowered(convPowered), .burstBusy(burstBusy)
    );
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Expected high byte after shift or justification
    function automatic logic [7:0] hiFmt(input logic [15:0] a, input logic [2:0] sj);
        logic [15:0] v;
        v = a;
        if (sj <= 3'h3) begin
            v = a >> sj;
        end else if (sj == 3'h4) begin
            v = {a[9:0], 6'h00};
        end
        return v[15:8];
    endfunction
    // One write; an idle cycle follows so strobes never re-assert in one step
    task automatic regWr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        sfrReq = '{wr: 1'b1, rd: 1'b0, page: pg, addr: ad, wdata: d};
        @(negedge ref_clk);
        sfrReq = '0;
        @(negedge ref_clk);
    endtask
    // One read, then compare the registered answer
    task automatic chkRd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] e,
                         input string nm);
        sfrReq = '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 8'h00};
        @(negedge ref_clk);
        sfrReq = '0;
        @(negedge ref_clk);
        `CHK(nm, e, sfrRdata)
    endtask
    // Run one burst, answering each start and timing first start and gaps
    task automatic runBurst(input int nExp, input int fLo, input int fHi, input int gLo,
                            input int gHi, output logic [15:0] sum);
        int cnt;
        int conv;
        logic [9:0] r;
        logic done;
        sum = 16'h0000;
        conv = 0;
        cnt = 0;
        done = 1'b0;
        startConv = 1'b1;
        while (!done) begin
            @(negedge ref_clk);
            startConv = 1'b0;
            convDone = 1'b0;
            cnt++;
            if (convStart === 1'b1) begin
                if (conv == 0) `CHK("first start delay", 1'b1, cnt >= fLo && cnt <= fHi)
                else `CHK("track gap", 1'b1, cnt >= gLo && cnt <= gHi)
                `CHK("powered while converting", 1'b1, convPowered)
                repeat (2) @(negedge ref_clk);
                // Random 10-bit result, accumulated here independently
                r = 10'($random(seed));
                convResult = r;
                convDone = 1'b1;
                sum = sum + 16'(r);
                conv++;
                cnt = 0;
            end else if (burstBusy !== 1'b1 || cnt > 3000) begin
                done = 1'b1;
            end
        end
        `CHK("conversion count", nExp, conv)
    endtask
    // Verdict and end of run
    task automatic finalReport();
        $display("compared %0d, errors %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog: the whole run needs well under 10000 cycles
    initial begin
        #300000;
        errorCnt++;
        finalReport();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic [15:0] s;
        logic [3:0] p;
        logic [5:0] t;
        int n;
        repeat (8) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        // Reset values and loose bits
        chkRd(PAGE_CFG, PWR_ADDR, 8'h0F, "power-up reset");
        chkRd(PAGE_CFG, TRK_ADDR, 8'h16, "track reset");
        chkRd(PAGE_DATA, RES_ADDR, 8'h00, "high byte reset");
        regWr(PAGE_CFG, PWR_ADDR, 8'h75);
        chkRd(PAGE_CFG, PWR_ADDR, 8'h05, "power-up upper bits");
        regWr(PAGE_CFG, TRK_ADDR, 8'hE9);
        chkRd(PAGE_CFG, TRK_ADDR, 8'h29, "track upper bits");
        chkRd(PAGE_DATA, PWR_ADDR, 8'h00, "unmapped place");
        // Every shift and justify code on a random written byte
        for (int i = 0; i < 8; i++) begin
            q = 8'($random(seed));
            regWr(PAGE_DATA, RES_ADDR, q);
            ctl.shiftJustifySelect = 3'(i);
            chkRd(PAGE_DATA, RES_ADDR, hiFmt({q, 8'h00}, 3'(i)), "formatted byte");
        end
        // Outside burst, power follows the enable alone
        ctl = '0;
        repeat (3) @(negedge ref_clk);
        `CHK("power with enable low", 1'b0, convPowered)
        ctl.converterEnable = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK("power with enable high", 1'b1, convPowered)
        // Every repeat code, shortest track gap, enable held
        regWr(PAGE_CFG, TRK_ADDR, 8'h3F);
        ctl.burstModeEnable = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ctl.repeatCount = 3'(i);
            n = (i == 0 || i > 5) ? 1 : (2 << i);
            runBurst(n, 1, 1, 2, 14, s);
            chkRd(PAGE_DATA, RES_ADDR, s[15:8], "accumulated byte");
            `CHK("power held after burst", 1'b1, convPowered)
        end
        // Delayed tracking adds three ticks before each start
        ctl.delayedTrackSelect = 1'b1;
        ctl.repeatCount = 3'h1;
        runBurst(4, 22, 34, 32, 44, s);
        // Enable clear: power-up wait first, low power afterwards
        p = 4'($random(seed)) & 4'h3;
        t = 6'h3C + (6'($random(seed)) & 6'h03);
        regWr(PAGE_CFG, PWR_ADDR, {4'h0, p});
        regWr(PAGE_CFG, TRK_ADDR, {2'b00, t});
        ctl.delayedTrackSelect = 1'b0;
        ctl.converterEnable = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK("power low before burst", 1'b0, convPowered)
        n = (int'(p) + 1) * 8;
        runBurst(4, 10 * n - 8, 10 * n + 4, 10 * (64 - int'(t)) - 8,
                 10 * (64 - int'(t)) + 4, s);
        repeat (2) @(negedge ref_clk);
        `CHK("power low after burst", 1'b0, convPowered)
        chkRd(PAGE_DATA, RES_ADDR, s[15:8], "four-sample sum");
        // Burst off with enable: one conversion that replaces the accumulator
        ctl.burstModeEnable = 1'b0;
        ctl.converterEnable = 1'b1;
        runBurst(1, 1, 1, 1, 1, s);
        chkRd(PAGE_DATA, RES_ADDR, s[15:8], "single result");
        finalReport();
    end
endmodule
`default_nettype wire
